// ===== mac_status_mode_regs.sv
// Status and operating-mode register bank of the DMA/MAC engine
`default_nettype none
`include "mac_regs_cfg.svh"

module mac_status_mode_regs
(
   input wire logic pclk,                          // System clock, 250 MHz
   input wire logic presetn,                       // Async reset, active low
   input wire logic psel,                          // APB select
   input wire logic penable,                       // APB access phase
   input wire logic pwrite,                        // APB direction, 1 is write
   input wire logic [`ADDR_WIDTH-1:0] paddr,       // APB byte address
   input wire mac_regs_pkg::word_t pwdata,         // APB write data
   output mac_regs_pkg::word_t prdata,             // APB read data
   output logic pready,                            // APB ready
   output logic pslverr,                           // APB error, unmapped address
   input wire mac_regs_pkg::tx_state_e tx_state,   // Live transmit process state
   input wire mac_regs_pkg::rx_state_e rx_state,   // Live receive process state
   input wire logic tx_frame_done,                 // Pulse: frame transmission ended
   input wire logic tx_first_irq_req,              // Completion-irq bit of first desc
   input wire logic [`ST_W1C_MSB:`ST_EVT_LSB] status_events, // Other status events
   input wire logic bus_err_valid,                 // Pulse: fatal bus error
   input wire mac_regs_pkg::bus_err_e bus_err_code, // Cause of the fatal error
   input wire logic soft_reset,                    // Software reset bit of bus mode
   input wire logic rx_addr_match,                 // Address filter result, this frame
   output logic enhanced_capture_enable,           // Enhanced capture resolution on
   output logic capture_effect_enable,             // Capture resolution on
   output logic receive_all_enable,                // Receive-all mode
   output logic scrambler_enable,                  // Scrambler active
   output logic coding_enable,                     // Coding functions active
   output logic symbol_ctrl_internal,              // Symbol port controls made inside
   output logic threshold_speed_select,            // 1: 10 Mb/s thresholds
   output logic port_select,                       // 0: serial port, 1: symbol port
   output logic frame_accept,                      // Accept current frame
   output logic match_report,                      // Match result for desc bit 30
   output logic device_halted                      // Halted after parity error
);
   import mac_regs_pkg::*;

   // ----------------------------------------
   // Internal wiring
   // ----------------------------------------
   regs_if rif ();                   // Carrier to the port and flags

   word_t mode_q;                    // Operating mode register
   word_t mode_d;                    // Next mode value
   tx_state_e tx_q;                  // Sampled transmit state
   rx_state_e rx_q;                  // Sampled receive state
   bus_err_e err_q;                  // Latched fatal error cause
   logic halted_q;                   // Halt after parity error
   logic accept_q;                   // Frame accept flop
   logic match_q;                    // Match report flop

   // ----------------------------------------
   // Bus port and flag bank
   // ----------------------------------------
   apb_port u_apb
   (
      .pclk (pclk),
      .presetn (presetn),
      .psel (psel),
      .penable (penable),
      .pwrite (pwrite),
      .paddr (paddr),
      .pwdata (pwdata),
      .prdata (prdata),
      .pready (pready),
      .pslverr (pslverr),
      .rif (rif.bus)
   );

   status_flags u_flags
   (
      .pclk (pclk),
      .presetn (presetn),
      .fif (rif.flag)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire sel_status = (rif.addr == `ADDR_STATUS);     // Status selected
   wire sel_mode = (rif.addr == `ADDR_MODE);         // Mode selected
   wire wr_status = rif.wr_stb & sel_status;         // Status write
   wire wr_mode = rif.wr_stb & sel_mode;             // Mode write

   assign rif.hit = sel_status | sel_mode;

   // ----------------------------------------
   // Status event sources
   // ----------------------------------------
   // Stopped entry detect
   // Compare against last cycle's state so reset alone raises nothing
   wire tx_enter_stop = (tx_state == TX_STOPPED) && (tx_q != TX_STOPPED);

   wire tx_complete_evt = tx_frame_done & tx_first_irq_req;

   // One driver for the whole set vector: events 16:2, stopped 1, complete 0
   assign rif.flag_set = {status_events, tx_enter_stop, tx_complete_evt};

   // Write-one clear
   // Zero bits of the write word leave the matching flag alone
   assign rif.flag_clr = wr_status ? rif.wdata[`ST_W1C_MSB:0] : '0;

   // ----------------------------------------
   // Status read word
   // ----------------------------------------
   // Live state fields
   // Bits 31:26 keep their reset ones; fields are read-only
   word_t status_rst;                // Reset image, source of the fixed ones
   word_t status_word;               // Assembled status
   assign status_rst = `STATUS_RESET;
   assign status_word = {
      status_rst[31:`ST_RSVD_LSB],
      err_q,
      tx_q,
      rx_q,
      rif.flags
   };

   assign rif.rdata = sel_status ? status_word : (sel_mode ? mode_q : 32'h0);

   // ----------------------------------------
   // Process state sampling
   // ----------------------------------------
   // Transmit state field
   // Suspended and running codes
   // One-cycle sample keeps the read path short; the value is never
   // more than one clock behind the processes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_q <= TX_STOPPED;
         rx_q <= RX_STOPPED;
      end
      else
      begin
         tx_q <= tx_state;
         rx_q <= rx_state;
      end
   end

   // ----------------------------------------
   // Fatal bus error and halt
   // ----------------------------------------
   // Latch error cause
   // No bus path to the field
   // The cause field is written by hardware only; bus writes never reach it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         err_q <= ERR_PARITY;
      else if (bus_err_valid)
         err_q <= bus_err_code;
   end

   // Parity halt hold
   // Only the software reset or the hardware reset releases the halt; a new parity error in the
   // same cycle wins so the fault is never silently dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         halted_q <= 1'b0;
      else if (bus_err_valid && (bus_err_code == ERR_PARITY))
         halted_q <= 1'b1;
      else if (soft_reset)
         halted_q <= 1'b0;
   end

   // ----------------------------------------
   // Operating mode register
   // ----------------------------------------
   // Coding off drops port select
   // Clearing the coding bit also forces the symbol port off, whatever
   // the write word carried in the port select bit
   always_comb
   begin
      mode_d = mode_q;
      if (wr_mode)
      begin
         mode_d = rif.wdata;
         if (!rif.wdata[`MD_CODING])
         begin
            mode_d[`MD_PORT_SEL] = 1'b0;
         end
      end
   end

   // Hardware reset only; software reset leaves the mode alone so that
   // the selected port survives a recovery
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= `MODE_RESET;
      else
         mode_q <= mode_d;
   end

   // ----------------------------------------
   // Receive-all frame acceptance
   // ----------------------------------------
   // Accept all, keep match
   // The filter result still goes to the descriptor even when everything
   // is accepted, so software can tell matched frames apart
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         accept_q <= 1'b0;
         match_q <= 1'b0;
      end
      else
      begin
         accept_q <= rx_addr_match | mode_q[`MD_RECV_ALL];
         match_q <= rx_addr_match;
      end
   end

   // ----------------------------------------
   // Mode outputs
   // ----------------------------------------
   // Enhanced capture enable
   assign enhanced_capture_enable = mode_q[`MD_ENH_CAPTURE];
   assign capture_effect_enable = mode_q[`MD_CAPTURE];
   assign receive_all_enable = mode_q[`MD_RECV_ALL];

   // Scrambler enable
   // Changing it live is not guarded here; software must avoid it
   assign scrambler_enable = mode_q[`MD_SCRAMBLE];

   assign coding_enable = mode_q[`MD_CODING];
   assign symbol_ctrl_internal = mode_q[`MD_CODING];

   // Threshold speed select
   // Taken as written; the transmit side must be stopped when it changes
   assign threshold_speed_select = mode_q[`MD_THRESH_10M];

   assign port_select = mode_q[`MD_PORT_SEL];

   assign frame_accept = accept_q;
   assign match_report = match_q;
   assign device_halted = halted_q;

endmodule // mac_status_mode_regs

`default_nettype wire

// ===== mac_regs_cfg.svh
// Offsets, field positions, reset values and widths of the status/mode registers
`ifndef MAC_REGS_CFG_SVH
`define MAC_REGS_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_WIDTH 8
`define ADDR_STATUS 8'h28
`define ADDR_MODE 8'h30

// ----------------------------------------
// Reset values
// ----------------------------------------
`define STATUS_RESET 32'hfc000000
`define MODE_RESET 32'h02000000

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define ST_TX_COMPLETE 0
`define ST_TX_STOPPED 1
`define ST_EVT_LSB 2
`define ST_W1C_MSB 16
`define W1C_WIDTH 17
`define ST_RX_LSB 17
`define ST_TX_LSB 20
`define ST_ERR_LSB 23
`define ST_RSVD_LSB 26
`define CODE_WIDTH 3

// ----------------------------------------
// Mode field positions
// ----------------------------------------
`define MD_CAPTURE 17
`define MD_PORT_SEL 18
`define MD_THRESH_10M 22
`define MD_CODING 23
`define MD_SCRAMBLE 24
`define MD_RECV_ALL 30
`define MD_ENH_CAPTURE 31

`endif

// ===== mac_regs_pkg.sv
// Types shared by the status/mode register bank
`default_nettype none

package mac_regs_pkg;

   // 32-bit register word
   typedef logic [31:0] word_t;

   // Transmit process state codes as reported in status
   typedef enum logic [2:0] {
      TX_STOPPED   = 3'h0,
      TX_FETCH     = 3'h1,
      TX_WAIT_END  = 3'h2,
      TX_READ_BUF  = 3'h3,
      TX_RESERVED  = 3'h4,
      TX_SETUP     = 3'h5,
      TX_SUSPENDED = 3'h6,
      TX_CLOSE     = 3'h7
   } tx_state_e;

   // Receive process state codes as reported in status
   typedef enum logic [2:0] {
      RX_STOPPED   = 3'h0,
      RX_FETCH     = 3'h1,
      RX_CHECK_END = 3'h2,
      RX_WAIT_PKT  = 3'h3,
      RX_SUSPENDED = 3'h4,
      RX_CLOSE     = 3'h5,
      RX_FLUSH     = 3'h6,
      RX_QUEUE     = 3'h7
   } rx_state_e;

   // Fatal bus error causes; other codes are reserved
   typedef enum logic [2:0] {
      ERR_PARITY       = 3'h0,
      ERR_MASTER_ABORT = 3'h1,
      ERR_TARGET_ABORT = 3'h2
   } bus_err_e;

endpackage : mac_regs_pkg

`default_nettype wire

// ===== regs_if.sv
// Internal carrier between the register core, its bus port and its flag bank
`default_nettype none
`include "mac_regs_cfg.svh"

interface regs_if;
   import mac_regs_pkg::*;

   logic wr_stb;                          // Write commits this cycle
   logic [`ADDR_WIDTH-1:0] addr;          // Held bus address
   word_t wdata;                          // Held bus write data
   word_t rdata;                          // Read word for addr
   logic hit;                             // Address is mapped
   logic [`W1C_WIDTH-1:0] flag_set;       // Hardware event per flag
   logic [`W1C_WIDTH-1:0] flag_clr;       // Software clear per flag
   logic [`W1C_WIDTH-1:0] flags;          // Sticky flag values

   modport core (output rdata, hit, flag_set, flag_clr,
                 input wr_stb, addr, wdata, flags);
   modport bus (input rdata, hit, output wr_stb, addr, wdata);
   modport flag (input flag_set, flag_clr, output flags);

endinterface : regs_if

`default_nettype wire

// ===== apb_port.sv
// APB slave port: one wait state, registered answer, commit at the pready edge
`default_nettype none
`include "mac_regs_cfg.svh"

module apb_port
(
   input wire logic pclk,                         // System clock
   input wire logic presetn,                      // Async reset, active low
   input wire logic psel,                         // APB select
   input wire logic penable,                      // APB access phase
   input wire logic pwrite,                       // APB direction
   input wire logic [`ADDR_WIDTH-1:0] paddr,      // APB byte address
   input wire mac_regs_pkg::word_t pwdata,        // APB write data
   output mac_regs_pkg::word_t prdata,            // APB read data
   output logic pready,                           // APB ready
   output logic pslverr,                          // APB error
   regs_if.bus rif                                // Register core side
);
   import mac_regs_pkg::*;

   // ----------------------------------------
   // Phase decode
   // ----------------------------------------
   word_t prdata_q;                  // Captured read word
   logic pready_q;                   // Ready flop
   logic pslverr_q;                  // Error flop
   wire first_access = psel & penable & ~pready_q;  // Access cycle one
   wire done = psel & penable & pready_q;           // Completing edge

   // The request is held stable by the master, so pass it straight in
   assign rif.addr = paddr;
   assign rif.wdata = pwdata;
   // Writes land only on the edge where pready is seen high
   assign rif.wr_stb = done & pwrite & rif.hit;

   // ----------------------------------------
   // Answer flops
   // ----------------------------------------
   // Read data is sampled one cycle before pready, which keeps every
   // bus output a flop at the cost of one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else if (first_access)
      begin
         pready_q <= 1'b1;
         pslverr_q <= ~rif.hit;
         prdata_q <= (rif.hit && !pwrite) ? rif.rdata : 32'h0;
      end
      else
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

endmodule // apb_port

`default_nettype wire

// ===== status_flags.sv
// Sticky status flags: hardware sets, software clears by writing one
`default_nettype none
`include "mac_regs_cfg.svh"

module status_flags
(
   input wire logic pclk,        // System clock
   input wire logic presetn,     // Async reset, active low
   regs_if.flag fif              // Set/clear in, flags out
);

   // ----------------------------------------
   // One flop per flag
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < `W1C_WIDTH; i++)
      begin : g_flag
         logic flag_q;           // Flag state
         // A set in the clearing cycle survives, so no event is lost
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               flag_q <= 1'(`STATUS_RESET >> i);
            else if (fif.flag_set[i])
               flag_q <= 1'b1;
            else if (fif.flag_clr[i])
               flag_q <= 1'b0;
         end
         assign fif.flags[i] = flag_q;
      end
   endgenerate

endmodule // status_flags

`default_nettype wire

// ===== mac_regs_props.sv
// Concurrent checks on the ports of the status/mode register bank
`default_nettype none
`include "mac_regs_cfg.svh"

module mac_regs_props
(
   input wire logic pclk,                            // System clock
   input wire logic presetn,                         // Async reset, active low
   input wire logic psel,                            // APB select
   input wire logic penable,                         // APB access phase
   input wire logic pwrite,                          // APB direction
   input wire logic [`ADDR_WIDTH-1:0] paddr,         // APB byte address
   input wire mac_regs_pkg::word_t prdata,           // APB read data
   input wire logic pready,                          // APB ready
   input wire logic pslverr,                         // APB error
   input wire logic bus_err_valid,                   // Fatal bus error pulse
   input wire mac_regs_pkg::bus_err_e bus_err_code,  // Fatal error cause
   input wire logic soft_reset,                      // Halt release request
   input wire logic rx_addr_match,                   // Address filter result
   input wire logic receive_all_enable,              // Receive-all mode
   input wire logic coding_enable,                   // Coding functions on
   input wire logic symbol_ctrl_internal,            // Symbol controls made inside
   input wire logic port_select,                     // Port select
   input wire logic frame_accept,                    // Frame accepted
   input wire logic match_report,                    // Match result copy
   input wire logic device_halted                    // Halt flag
);
   import mac_regs_pkg::*;

   // ----------------------------------------
   // Clocking, decode and sequences
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Address decode; only two words are mapped
   wire logic mapped = (paddr == `ADDR_STATUS) || (paddr == `ADDR_MODE);
   // Access phase still waiting for its answer
   sequence s_access; psel && penable && !pready; endsequence
   // Parity error reported by the bus engine
   sequence s_parity; bus_err_valid && bus_err_code == ERR_PARITY; endsequence

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_mapped_answer: assert property (s_access ##0 mapped |=> pready && !pslverr)
      else $error("mapped access not answered in one cycle");
   a_unmapped_refused: assert property (s_access ##0 !mapped |=> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_status_top_ones: assert property (
      pready && !pslverr && !pwrite && paddr == `ADDR_STATUS |-> prdata[31:26] == 6'h3f)
      else $error("status upper bits not ones");
   a_parity_halts: assert property (s_parity |=> device_halted)
      else $error("parity error did not halt");
   a_halt_holds: assert property (device_halted && !soft_reset |=> device_halted)
      else $error("halt left without software reset");
   a_halt_release: assert property (
      soft_reset && !(bus_err_valid && bus_err_code == ERR_PARITY) |=> !device_halted)
      else $error("software reset did not release halt");
   a_symbol_ctrl_tie: assert property (symbol_ctrl_internal == coding_enable)
      else $error("symbol control differs from coding enable");
   a_port_gate: assert property (!coding_enable |-> !port_select)
      else $error("port select set while coding off");
   a_accept_follow: assert property (
      1'b1 |=> frame_accept == $past(receive_all_enable || rx_addr_match))
      else $error("frame accept wrong");
   a_match_copy: assert property (1'b1 |=> match_report == $past(rx_addr_match))
      else $error("match report wrong");

endmodule // mac_regs_props

bind mac_status_mode_regs mac_regs_props props_u
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .bus_err_valid, .bus_err_code, .soft_reset, .rx_addr_match, .receive_all_enable,
   .coding_enable, .symbol_ctrl_internal, .port_select, .frame_accept, .match_report,
   .device_halted
);

`default_nettype wire

// ===== mac_status_mode_regs_test.sv
// Self-checking testbench of the status/mode register bank
`default_nettype none
`include "mac_regs_cfg.svh"

module mac_status_mode_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import mac_regs_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic pclk, presetn, psel, penable, pwrite; // Clock, reset, bus controls
   logic [`ADDR_WIDTH-1:0] paddr; // Bus address
   word_t pwdata, prdata; // Bus data
   logic pready, pslverr; // Bus answer
   tx_state_e tx_state; // Transmit state in
   rx_state_e rx_state; // Receive state in
   logic tx_frame_done, tx_first_irq_req, bus_err_valid, soft_reset, rx_addr_match;
   logic [`ST_W1C_MSB:`ST_EVT_LSB] status_events; // Event pulses
   bus_err_e bus_err_code; // Error cause in
   wire logic [7:0] mode_o; // Mode pins, bit 31 first down to port select
   logic frame_accept, match_report, device_halted; // Other outputs
   int err_total, cmp_count; // Mismatch and comparison counts
   word_t rd; // Last read word
   logic er; // Last error flag

   mac_status_mode_regs dut_u
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_state(tx_state), .rx_state(rx_state), .tx_frame_done(tx_frame_done),
      .tx_first_irq_req(tx_first_irq_req), .status_events(status_events),
      .bus_err_valid(bus_err_valid), .bus_err_code(bus_err_code), .soft_reset(soft_reset),
      .rx_addr_match(rx_addr_match), .enhanced_capture_enable(mode_o[7]),
      .capture_effect_enable(mode_o[6]), .receive_all_enable(mode_o[5]),
      .scrambler_enable(mode_o[4]), .coding_enable(mode_o[3]),
      .symbol_ctrl_internal(mode_o[2]), .threshold_speed_select(mode_o[1]),
      .port_select(mode_o[0]), .frame_accept(frame_accept), .match_report(match_report),
      .device_halted(device_halted)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Compare and count; case inequality so unknowns never match
   task automatic chk(input string name, input word_t got, input word_t exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; entered at an edge, leaves one idle cycle behind
   task automatic xfer(input logic w, input logic [`ADDR_WIDTH-1:0] a, input word_t d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("ready", word_t'(pready), 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read a word and compare the masked bits
   task automatic rchk(input string name, input logic [`ADDR_WIDTH-1:0] a, input word_t exp,
                       input word_t mask);
      xfer(1'b0, a, 32'h0);
      chk(name, rd & mask, exp & mask);
      chk("mapped no error", word_t'(er), 32'h0);
   endtask

   // Single place where the run ends
   task automatic results();
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------
   // 250 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Tests need under 150 cycles; a hang ends as a failure
   initial
   begin
      repeat (3000) @(posedge pclk);
      err_total++;
      results();
   end

   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, tx_frame_done, tx_first_irq_req} <= '0;
      {bus_err_valid, soft_reset, rx_addr_match, paddr, pwdata, status_events} <= '0;
      tx_state <= TX_STOPPED;
      rx_state <= RX_STOPPED;
      bus_err_code <= ERR_PARITY;
      err_total = 0;
      cmp_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("status reset", `ADDR_STATUS, `STATUS_RESET, '1);
      rchk("mode reset", `ADDR_MODE, `MODE_RESET, '1);
      xfer(1'b0, 8'h00, 32'h0);
      chk("unmapped err", word_t'(er), 32'h1);
      chk("unmapped data", rd, 32'h0);
      // Every mode field set, then coding off with port select requested
      // No other control left to set
      xfer(1'b1, `ADDR_MODE, 32'hc3c60000);
      rchk("mode all", `ADDR_MODE, 32'hc3c60000, '1);
      chk("mode pins all", word_t'(mode_o), 32'hff);
      xfer(1'b1, `ADDR_MODE, 32'h02040000);
      rchk("mode no coding", `ADDR_MODE, 32'h02000000, '1);
      chk("mode pins none", word_t'(mode_o), 32'h00);
      chk("accept none", word_t'(frame_accept), 32'h0);
      xfer(1'b1, `ADDR_MODE, 32'h42400000);
      chk("mode pins ra tt", word_t'(mode_o), 32'h22);
      repeat (2) @(posedge pclk);
      chk("accept all", word_t'(frame_accept), 32'h1);
      // Sticky flags: set all event flags 16:2, clear even ones 14:2, fields not writable
      status_events <= '1;
      @(posedge pclk);
      status_events <= '0;
      xfer(1'b1, `ADDR_STATUS, 32'h03fe5554);
      rchk("flags part", `ADDR_STATUS, 32'hfc01aaa8, '1);
      xfer(1'b1, `ADDR_STATUS, 32'h0001ffff);
      rchk("flags none", `ADDR_STATUS, 32'hfc000000, '1);
      // Frame done sets the completion flag only when requested
      for (int j = 0; j < 2; j++)
      begin
         tx_first_irq_req <= j[0];
         tx_frame_done <= 1'b1;
         @(posedge pclk);
         tx_frame_done <= 1'b0;
         rchk("tx complete", `ADDR_STATUS, word_t'(j), 32'h1);
      end
      // Every transmit and receive state code shows live
      for (int i = 0; i < 8; i++)
      begin
         tx_state <= tx_state_e'(i);
         rx_state <= rx_state_e'(7 - i);
         rx_addr_match <= i[0];
         repeat (2) @(posedge pclk);
         rchk("states", `ADDR_STATUS, {9'h0, 3'(i), 3'(7 - i), 17'h0}, 32'h007e0000);
         chk("match copy", word_t'(match_report), word_t'(i[0]));
         chk("accept ra", word_t'(frame_accept), 32'h1);
      end
      tx_state <= TX_STOPPED;
      repeat (2) @(posedge pclk);
      rchk("tx stopped", `ADDR_STATUS, 32'h2, 32'h2);
      // Bus error causes; only parity halts, software reset releases
      for (int i = 2; i >= 0; i--)
      begin
         bus_err_code <= bus_err_e'(i);
         bus_err_valid <= 1'b1;
         @(posedge pclk);
         bus_err_valid <= 1'b0;
         rchk("err code", `ADDR_STATUS, {6'h0, 3'(i), 23'h0}, 32'h03800000);
         chk("halted", word_t'(device_halted), word_t'(i == 0));
      end
      soft_reset <= 1'b1;
      @(posedge pclk);
      soft_reset <= 1'b0;
      @(posedge pclk);
      chk("released", word_t'(device_halted), 32'h0);
      results();
   end

endmodule // mac_status_mode_regs_test

`default_nettype wire
